// ---- src/fcct_channel.sv ----
`timescale 1ns/10ps
`include "fcct_consts.svh"

module fcct_channel (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wr,
	input wire logic [7:0] i_data,
	input wire logic i_trig,
	input wire logic i_glob_run,
	output logic o_zero,
	output logic o_irq,
	output logic [7:0] o_count
);
	// ***************************************************************
	// control and reload storage
	// ***************************************************************
	fcct_pkg::fcct_byte_t ctrl;
	fcct_pkg::fcct_byte_t reload_value;
	fcct_pkg::fcct_state_e state;
	logic tc_pending;
	logic tc_valid;
	logic trig_q;
	logic trig_seen;
	logic [7:0] down;
	logic [7:0] presc;
	logic [1:0] arm_cnt;

	wire is_tc_write = i_wr & tc_pending;
	wire is_ctrl_write = i_wr & ~tc_pending & i_data[`FCCT_BIT_CTRL];
	wire sw_reset = is_ctrl_write & i_data[`FCCT_BIT_SWRST];
	wire counter_mode = ctrl[`FCCT_BIT_MODE];
	wire rise_sel = ctrl[`FCCT_BIT_EDGE];
	// edge chosen by bit 4 in both modes
	wire trig_edge = rise_sel ? (i_trig & ~trig_q) : (~i_trig & trig_q);
	// trigger edge is latched and counted on the next clock edge
	wire [7:0] presc_last = ctrl[`FCCT_BIT_PRESC] ? `FCCT_PRESC256_LAST
		: `FCCT_PRESC16_LAST;
	wire presc_tick = (presc == presc_last) & ~counter_mode;
	wire dec_evt = (state == fcct_pkg::FCCT_RUN) & i_glob_run
		& (counter_mode ? trig_seen : presc_tick);
	wire hit_zero = dec_evt & (down == 8'h01);
	wire next_trig_seen = trig_edge & counter_mode;

	// ***************************************************************
	// write decode
	// ***************************************************************
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl <= `FCCT_CTRL_RST;
			reload_value <= 8'h00;
			tc_pending <= 1'b0;
			tc_valid <= 1'b0;
		end else if (is_tc_write) begin
			reload_value <= i_data;
			tc_pending <= 1'b0;
			tc_valid <= 1'b1;
		end else if (is_ctrl_write) begin
			// software reset bit itself is not stored
			ctrl <= i_data & ~(8'h01 << `FCCT_BIT_SWRST);
			tc_pending <= i_data[`FCCT_BIT_TCF];
		end
	end

	// ***************************************************************
	// run sequencing
	// ***************************************************************
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= fcct_pkg::FCCT_IDLE;
			trig_q <= 1'b0;
			trig_seen <= 1'b0;
			arm_cnt <= 2'h0;
		end else begin
			trig_q <= i_trig;
			trig_seen <= next_trig_seen;
			unique case (state)
				fcct_pkg::FCCT_IDLE: begin
					// timer start armed by write when not in reset-only control word
					if (is_tc_write || (is_ctrl_write && !sw_reset && tc_valid
						&& !i_data[`FCCT_BIT_TCF])) begin
						if (!i_data[`FCCT_BIT_MODE] && is_ctrl_write
							&& i_data[`FCCT_BIT_TRIG])
							state <= fcct_pkg::FCCT_WAIT_TRIG;
						else if (is_tc_write && !counter_mode && ctrl[`FCCT_BIT_TRIG])
							state <= fcct_pkg::FCCT_WAIT_TRIG;
						else
							state <= fcct_pkg::FCCT_RUN;
					end
				end
				fcct_pkg::FCCT_WAIT_TRIG: begin
					if (sw_reset)
						state <= fcct_pkg::FCCT_IDLE;
					else if (trig_edge) begin
						state <= fcct_pkg::FCCT_ARMING;
						arm_cnt <= `FCCT_START_DLY - 2'h1;
					end
				end
				fcct_pkg::FCCT_ARMING: begin
					if (sw_reset)
						state <= fcct_pkg::FCCT_IDLE;
					else if (arm_cnt == 2'h0)
						state <= fcct_pkg::FCCT_RUN;
					else
						arm_cnt <= arm_cnt - 2'h1;
				end
				fcct_pkg::FCCT_RUN: begin
					if (sw_reset)
						state <= fcct_pkg::FCCT_IDLE;
				end
			endcase
		end
	end

	// ***************************************************************
	// prescaler and down-counter
	// ***************************************************************
	wire starting = (state != fcct_pkg::FCCT_RUN);
	// a reload written on the starting edge must be the first count loaded
	wire [7:0] load_value = is_tc_write ? i_data : reload_value;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			down <= 8'h00;
			presc <= 8'h00;
			o_zero <= 1'b0;
			o_irq <= 1'b0;
		end else begin
			o_zero <= hit_zero;
			// enable applies only to zero counts after it is set
			o_irq <= hit_zero & ctrl[`FCCT_BIT_IE];
			if (starting) begin
				presc <= 8'h00;
				down <= load_value;
			end else begin
				presc <= presc_tick ? 8'h00 : presc + 8'h01;
				// reload picks up a new value only at zero
				if (hit_zero)
					down <= reload_value;
				else if (dec_evt)
					down <= down - 8'h01;
			end
		end
	end

	assign o_count = down;
endmodule : fcct_channel

// ---- src/fcct_consts.svh ----
`ifndef FCCT_CONSTS_SVH
`define FCCT_CONSTS_SVH
// control word field positions
`define FCCT_BIT_CTRL 0
`define FCCT_BIT_SWRST 1
`define FCCT_BIT_TCF 2
`define FCCT_BIT_TRIG 3
`define FCCT_BIT_EDGE 4
`define FCCT_BIT_PRESC 5
`define FCCT_BIT_MODE 6
`define FCCT_BIT_IE 7
// reset values
`define FCCT_CTRL_RST 8'h00
`define FCCT_VEC_RST 8'h00
// prescaler terminal counts (factor minus one)
`define FCCT_PRESC16_LAST 8'h0F
`define FCCT_PRESC256_LAST 8'hFF
// trigger-to-start delay in system clocks
`define FCCT_START_DLY 2'h2
`endif

// ---- src/fcct_pkg.sv ----
package fcct_pkg;
	typedef enum logic [1:0] {
		FCCT_IDLE,
		FCCT_WAIT_TRIG,
		FCCT_ARMING,
		FCCT_RUN
	} fcct_state_e;
	typedef logic [7:0] fcct_byte_t;
endpackage : fcct_pkg

// ---- src/fcct_top.sv ----
`timescale 1ns/10ps
`include "fcct_consts.svh"

module fcct_top (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_chip_en_n,
	input wire logic i_ioreq_n,
	input wire logic i_rd_n,
	input wire logic i_m1_n,
	input wire logic i_channel_sel_lo,
	input wire logic i_channel_sel_hi,
	input wire logic [7:0] i_data,
	input wire logic i_int_ack,
	input wire logic [3:0] i_ext_clock_trigger,
	output logic [7:0] o_data,
	output logic o_data_oe,
	output logic [2:0] o_zero_count_pulse,
	output logic o_int_n,
	output logic o_int_oe
);
	// ***************************************************************
	// access decode
	// ***************************************************************
	wire [1:0] sel = {i_channel_sel_hi, i_channel_sel_lo};
	wire access = ~i_chip_en_n & ~i_ioreq_n & i_m1_n;
	wire wr_cyc = access & i_rd_n;
	wire rd_cyc = access & ~i_rd_n;
	logic wr_q;
	// one write strobe per cycle, taken on its first clock
	wire wr_stb = wr_cyc & ~wr_q;
	wire [3:0] ch_wr;
	wire [3:0] zero_pulse;
	wire [3:0] irq_evt;
	wire [7:0] count [4];
	logic [7:0] vector;
	logic [3:0] irq_pend;

	// vector write goes to vector register whatever channel is selected
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ch
			assign ch_wr[g] = wr_stb & (sel == 2'(g));
			fcct_channel u_ch (
				.i_clk(i_clk),
				.i_rst(i_rst),
				.i_wr(ch_wr[g]),
				.i_data(i_data),
				.i_trig(i_ext_clock_trigger[g]),
				.i_glob_run(1'b1),
				.o_zero(zero_pulse[g]),
				.o_irq(irq_evt[g]),
				.o_count(count[g])
			);
		end
	endgenerate

	// ***************************************************************
	// vector and interrupt request
	// ***************************************************************
	// a vector byte is one with bit 0 clear that is not a reload value;
	// expect_tc mirrors each channel's reload-pending flag, so both it and the low bit are checked here
	logic [3:0] expect_tc;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			expect_tc <= 4'h0;
		else if (wr_stb) begin
			if (expect_tc[sel])
				expect_tc[sel] <= 1'b0;
			else if (i_data[`FCCT_BIT_CTRL])
				expect_tc[sel] <= i_data[`FCCT_BIT_TCF];
		end
	end
	wire vec_wr = wr_stb & ~expect_tc[sel] & ~i_data[`FCCT_BIT_CTRL];

	// lowest channel number is highest priority
	wire [1:0] top_chan = irq_pend[0] ? 2'h0 : irq_pend[1] ? 2'h1
		: irq_pend[2] ? 2'h2 : 2'h3;
	wire [3:0] ack_clr = i_int_ack ? (4'h1 << top_chan) : 4'h0;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			vector <= `FCCT_VEC_RST;
			irq_pend <= 4'h0;
			wr_q <= 1'b0;
			o_data <= 8'h00;
			o_data_oe <= 1'b0;
			o_zero_count_pulse <= 3'h0;
			o_int_n <= 1'b1;
			o_int_oe <= 1'b0;
		end else begin
			wr_q <= wr_cyc;
			if (vec_wr)
				vector <= i_data;
			// a new event wins over the acknowledge clear
			irq_pend <= (irq_pend & ~ack_clr) | irq_evt;
			o_zero_count_pulse <= zero_pulse[2:0];
			o_int_n <= ~(|irq_pend);
			o_int_oe <= |irq_pend;
			o_data_oe <= rd_cyc | i_int_ack;
			if (i_int_ack)
				o_data <= {vector[7:3], top_chan, 1'b0};
			else
				o_data <= count[sel];
		end
	end
endmodule : fcct_top

// ---- verification/fcct_chk.sv ----
`timescale 1ns/10ps
module fcct_chk (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_chip_en_n,
	input wire logic i_ioreq_n,
	input wire logic i_rd_n,
	input wire logic i_m1_n,
	input wire logic i_int_ack,
	input wire logic [7:0] o_data,
	input wire logic o_data_oe,
	input wire logic [2:0] o_zero_count_pulse,
	input wire logic o_int_n,
	input wire logic o_int_oe
);
	wire logic rd = !i_chip_en_n && !i_ioreq_n && i_m1_n && !i_rd_n;
	wire logic wr = !i_chip_en_n && !i_ioreq_n && i_m1_n && i_rd_n;
	wire logic [2:0] zc = o_zero_count_pulse;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	property p_one; zc != 3'h0 |=> (zc & $past(zc)) == 3'h0; endproperty
	a_one: assert property (p_one) else $error("pulse too long");
	property p_od; o_int_oe == !o_int_n; endproperty
	a_od: assert property (p_od) else $error("request drive");
	property p_rd; rd |=> o_data_oe; endproperty
	a_rd: assert property (p_rd) else $error("read not driven");
	property p_hiz; !rd && !i_int_ack |=> !o_data_oe; endproperty
	a_hiz: assert property (p_hiz) else $error("bus driven");
	property p_vec; i_int_ack && !rd |=> o_data_oe && !o_data[0]; endproperty
	a_vec: assert property (p_vec) else $error("vector");
	property p_rel; $fell(i_rst) |-> o_int_n && !o_data_oe && zc == 3'h0; endproperty
	a_rel: assert property (p_rel) else $error("reset state");
	property p_idle; $fell(i_rst) |-> (zc == 3'h0 && o_int_n) [*8]; endproperty
	a_idle: assert property (p_idle) else $error("runs unloaded");
	property p_hold; !o_int_n && !i_int_ack && !$past(i_int_ack) |=> !o_int_n; endproperty
	a_hold: assert property (p_hold) else $error("request lost");
endmodule : fcct_chk
bind fcct_top fcct_chk i_fcct_chk (.i_clk, .i_rst, .i_chip_en_n, .i_ioreq_n, .i_rd_n, .i_m1_n,
	.i_int_ack, .o_data, .o_data_oe, .o_zero_count_pulse, .o_int_n, .o_int_oe);

// ---- verification/fcct_cpu.sv ----
`timescale 1ns/10ps
module fcct_cpu (
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output logic o_acc_n,
	output logic o_rd_n,
	output logic o_ack,
	output logic [1:0] o_sel,
	output logic [7:0] o_wdata
);
	initial {o_acc_n, o_rd_n, o_ack, o_sel, o_wdata} = {3'b110, 2'h0, 8'hA5};
	// k: 0 write, 1 read, 2 acknowledge; a full idle clock follows each access
	task acc(input logic [1:0] k, input logic [1:0] ch, input logic [7:0] din,
		output logic [7:0] dout);
		@(negedge i_clk);
		{o_sel, o_wdata, o_ack, o_rd_n, o_acc_n} = {ch, din, k == 2'h2, k != 2'h1, k == 2'h2};
		@(negedge i_clk);
		dout = i_rdata;
		{o_ack, o_rd_n, o_acc_n, o_wdata} = {3'b011, ~din};
		@(negedge i_clk);
	endtask : acc
endmodule : fcct_cpu

// ---- verification/fcct_top_tb.sv ----
`timescale 1ns/10ps
// ****
// bench
// ****
module fcct_top_tb;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] trig = 4'h0;
	logic acc_n, rd_n, ack, oe, int_n, int_oe;
	logic [1:0] sel;
	logic [7:0] wd, rdat, d, c;
	logic [2:0] zc;
	int miscompares = 0, n_tests = 0, cyc = 0, e, n, cnt, p, base;
	int pulses [4] = '{0, 0, 0, 0};
	fcct_top i_fcct_top (.i_clk, .i_rst, .i_chip_en_n(acc_n), .i_ioreq_n(acc_n), .i_rd_n(rd_n),
		.i_m1_n(~ack), .i_channel_sel_lo(sel[0]), .i_channel_sel_hi(sel[1]), .i_data(wd),
		.i_int_ack(ack), .i_ext_clock_trigger(trig), .o_data(rdat), .o_data_oe(oe),
		.o_zero_count_pulse(zc), .o_int_n(int_n), .o_int_oe(int_oe));
	fcct_cpu i_fcct_cpu (.i_clk, .i_rdata(rdat), .o_acc_n(acc_n), .o_rd_n(rd_n), .o_ack(ack),
		.o_sel(sel), .o_wdata(wd));
	initial forever #50 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		for (int k = 0; k < 3; k++)
			pulses[k] <= pulses[k] + int'(zc[k] === 1'b1);
		if (cyc == 20000) begin
			miscompares++;
			final_report();
		end
	end
	task chk(input logic [15:0] got, input logic [15:0] want);
		n_tests++;
		if (got !== want) begin
			miscompares++;
			$display("mismatch at %0t: %h not %h", $time, got, want);
		end
	endtask : chk
	// three clocks per level so every edge is seen and counted before the next
	task set_trig(input int ch, input logic v);
		@(negedge i_clk);
		trig[ch] = v;
		repeat (3) @(negedge i_clk);
	endtask : set_trig
	task timer(input int ch, input logic [7:0] cw, input int tc);
		int pf, g, t;
		pf = cw[5] ? 256 : 16;
		set_trig(ch, !cw[4]);
		i_fcct_cpu.acc(2'h0, 2'(ch), cw, d);
		i_fcct_cpu.acc(2'h0, 2'(ch), 8'(tc), d);
		g = pulses[ch];
		if (cw[3]) begin
			repeat (40) @(negedge i_clk);
			chk(16'(pulses[ch] - g), 16'h0);
			set_trig(ch, cw[4]);
		end
		t = cyc;
		wait (pulses[ch] == g + 1);
		chk(16'(cyc - t >= pf * tc && cyc - t <= pf * tc + 6), 16'h1);
		t = cyc;
		wait (pulses[ch] == g + 2);
		chk(16'(cyc - t), 16'(pf * tc));
	endtask : timer
	task final_report;
		$display("tests %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	initial begin
		void'($urandom(32'h83e2));
		repeat (8) @(negedge i_clk);
		i_rst = 1'b0;
		for (int ch = 0; ch < 4; ch++) begin
			e = $urandom_range(1, 0);
			n = (ch == 0) ? 256 : $urandom_range(6, 2);
			c = 8'h45 | 8'(e << 4) | (8'($urandom) & 8'h28);
			set_trig(ch, !e);
			i_fcct_cpu.acc(2'h0, 2'(ch), c, d);
			i_fcct_cpu.acc(2'h0, 2'(ch), 8'(n), d);
			cnt = n;
			p = 0;
			base = pulses[ch];
			for (int j = 0; j <= n; j++) begin
				if (j > 0)
					set_trig(ch, !e);
				set_trig(ch, e);
				p += (cnt == 1);
				cnt = (cnt == 1) ? n : cnt - 1;
			end
			i_fcct_cpu.acc(2'h1, 2'(ch), 8'h00, d);
			chk(16'(d), 16'(cnt % 256));
			if (ch < 3)
				chk(16'(pulses[ch] - base), 16'(p));
		end
		timer(1, 8'h07, $urandom_range(4, 1));
		timer(1, 8'h27, 1);
		timer(0, 8'h1F, 2);
		i_fcct_cpu.acc(2'h0, 2'h0, 8'hA8, d);
		set_trig(2, 1'b0);
		i_fcct_cpu.acc(2'h0, 2'h2, 8'hD7, d);
		i_fcct_cpu.acc(2'h0, 2'h2, 8'h01, d);
		chk(16'(int_n), 16'h1);
		set_trig(2, 1'b1);
		@(negedge i_clk);
		chk(16'(int_n), 16'h0);
		i_fcct_cpu.acc(2'h2, 2'h0, 8'h00, d);
		chk(16'(d), 16'h00AC);
		repeat (2) @(negedge i_clk);
		chk(16'(int_n), 16'h1);
		set_trig(3, 1'b0);
		i_fcct_cpu.acc(2'h0, 2'h3, 8'h03, d);
		i_fcct_cpu.acc(2'h0, 2'h3, 8'h19, d);
		repeat (20) @(negedge i_clk);
		i_fcct_cpu.acc(2'h1, 2'h3, 8'h00, d);
		chk(16'(d), 16'(8'(n)));
		set_trig(3, 1'b1);
		repeat (20) @(negedge i_clk);
		i_fcct_cpu.acc(2'h1, 2'h3, 8'h00, d);
		chk(16'(d), 16'(8'(n - 1)));
		final_report();
	end
endmodule : fcct_top_tb
